// File: core/startup_and_clock_select.sv
/*
 * Start-up sequencer, wake-up latency control and main clock
 * configuration registers behind an APB slave.
 * Assumes oscillator, reset and wake pins are asynchronous to pclk and
 * the fuse level bod_enable is static; wdt_reset and sleep_req are pclk logic.
 */
`timescale 1ns/1ps
module startup_and_clock_select #(
    parameter int unsigned RESET_TICKS = clock_ctrl_pkg::RESET_DELAY_TICKS,
    parameter int unsigned BOD_RESET_TICKS = clock_ctrl_pkg::BOD_RESET_DELAY_TICKS,
    parameter int unsigned BOD_WAKE_TICKS = clock_ctrl_pkg::BOD_WAKE_CYCLES,
    // Arbitrary value
    parameter logic [7:0] UNLOCK_SIGNATURE = 8'h5a
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [9:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic clk_fast_osc,
    input wire logic clk_slow_osc,
    input wire logic clk_ext,
    input wire logic ext_reset_n,
    input wire logic bod_reset,
    input wire logic wdt_reset,
    input wire logic bod_enable,
    input wire logic [7:0] factory_cal,
    input wire logic sleep_req,
    input wire logic [2:0] sleep_mode,
    input wire logic bod_sleep_off,
    input wire logic wake_event,
    output logic sys_reset_n,
    output logic cpu_hold,
    output logic fast_osc_enable,
    output logic main_clk,
    output logic sys_clk,
    output logic sys_tick,
    output logic [7:0] osc_trim
);
    import clock_ctrl_pkg::*;

    // ************************************************************
    // Declarations
    // ************************************************************
    seq_state_t state_reg, state_next;
    logic [15:0] cnt_reg, cnt_next;
    logic [15:0] wcnt_reg, wcnt_next;
    logic por_reg, por_next;
    logic released_reg, released_next;
    logic [2:0] mode_reg, mode_next;
    logic bodoff_reg, bodoff_next;
    logic osc_en_reg, osc_en_next;
    logic [2:0] s1_reg, s2_reg, s3_reg, pin_reg, pin_next;
    logic [1:0] src_reg, src_next;
    logic [3:0] div_reg, div_next;
    logic [7:0] trim_reg, trim_next;
    logic [2:0] win_reg, win_next;
    logic [31:0] rdata_reg, rdata_next;
    logic main_tick;
    logic [2:0] src_tick;
    logic [1:0] active_src;
    logic [3:0] active_div;
    logic reset_src;
    logic [15:0] supply_target;
    logic osc_ok, bod_ok;
    logic [7:0] idx;
    logic mapped, wr;

    // ************************************************************
    // Clock path
    // ************************************************************
    clock_source_mux u_mux (
        .pclk(pclk),
        .presetn(presetn),
        .osc_in({clk_ext, clk_slow_osc, clk_fast_osc}),
        .sel(src_reg),
        .main_clk(main_clk),
        .main_tick(main_tick),
        .src_tick(src_tick),
        .active_sel(active_src)
    );

    system_clock_prescaler u_div (
        .pclk(pclk),
        .presetn(presetn),
        .main_tick(main_tick),
        .main_clk(main_clk),
        .code(div_reg),
        .sys_tick(sys_tick),
        .sys_clk(sys_clk),
        .active_code(active_div)
    );

    // ************************************************************
    // Pin synchronisers: ext reset, brown-out reset, wake
    // ************************************************************
    always_comb begin
        pin_next = agree_filter(s2_reg, s3_reg, pin_reg);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_reg <= 3'h0;
            s2_reg <= 3'h0;
            s3_reg <= 3'h0;
            pin_reg <= 3'h0;
        end else begin
            s1_reg <= {wake_event, bod_reset, ~ext_reset_n};
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            pin_reg <= pin_next;
        end
    end

    assign reset_src = pin_reg[0] | pin_reg[1] | wdt_reset;
    assign sys_reset_n = presetn & ext_reset_n & ~bod_reset & ~wdt_reset & released_reg;

    // ************************************************************
    // Start-up and wake sequencer
    // ************************************************************
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        wcnt_next = wcnt_reg;
        por_next = por_reg;
        released_next = released_reg;
        mode_next = mode_reg;
        bodoff_next = bodoff_reg;
        osc_en_next = 1'b1;
        supply_target = (por_reg && bod_enable) ? 16'(BOD_RESET_TICKS) : 16'(RESET_TICKS);
        osc_ok = mode_reg != MODE_PDOWN || cnt_reg >= OSC_START_TICKS;
        bod_ok = !bodoff_reg || wcnt_reg >= 16'(BOD_WAKE_TICKS);
        if (reset_src) begin
            state_next = ST_HOLD;
            cnt_next = 16'h0000;
            released_next = 1'b0;
        end else begin
            case (state_reg)
                ST_HOLD: begin
                    state_next = ST_SUPPLY;
                    cnt_next = 16'h0000;
                end
                ST_SUPPLY: begin
                    if (src_tick[SRC_SLOW]) begin
                        if (count_done(cnt_reg, supply_target)) begin
                            state_next = ST_OSC;
                            cnt_next = 16'h0000;
                            por_next = 1'b0;
                        end else begin
                            cnt_next = cnt_reg + 16'h0001;
                        end
                    end
                end
                ST_OSC: begin
                    if (src_tick[SRC_FAST]) begin
                        if (count_done(cnt_reg, OSC_START_TICKS)) begin
                            state_next = ST_CONFIG;
                            cnt_next = 16'h0000;
                        end else begin
                            cnt_next = cnt_reg + 16'h0001;
                        end
                    end
                end
                ST_CONFIG: begin
                    if (sys_tick) begin
                        if (count_done(cnt_reg, CONFIG_LOAD_TICKS)) begin
                            state_next = ST_RUN;
                            cnt_next = 16'h0000;
                            released_next = 1'b1;
                        end else begin
                            cnt_next = cnt_reg + 16'h0001;
                        end
                    end
                end
                ST_RUN: begin
                    if (sleep_req) begin
                        state_next = ST_SLEEP;
                        mode_next = sleep_mode;
                        bodoff_next = bod_sleep_off && (sleep_mode == MODE_PDOWN || sleep_mode == MODE_STBY);
                    end
                end
                ST_SLEEP: begin
                    // Oscillator stops only in power-down
                    osc_en_next = mode_reg != MODE_PDOWN;
                    cnt_next = 16'h0000;
                    wcnt_next = 16'h0000;
                    if (pin_reg[2]) begin
                        osc_en_next = 1'b1;
                        if (mode_reg != MODE_PDOWN && !bodoff_reg) begin
                            state_next = ST_RUN;
                        end else begin
                            state_next = ST_WAKE;
                        end
                    end
                end
                ST_WAKE: begin
                    if (main_tick && !osc_ok) begin
                        cnt_next = cnt_reg + 16'h0001;
                    end
                    if (!bod_ok) begin
                        wcnt_next = wcnt_reg + 16'h0001;
                    end
                    if (osc_ok && bod_ok) begin
                        state_next = ST_RUN;
                        bodoff_next = 1'b0;
                    end
                end
                default: begin
                    state_next = ST_HOLD;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= ST_HOLD;
            cnt_reg <= 16'h0000;
            wcnt_reg <= 16'h0000;
            por_reg <= 1'b1;
            released_reg <= 1'b0;
            mode_reg <= MODE_IDLE;
            bodoff_reg <= 1'b0;
            osc_en_reg <= 1'b1;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            wcnt_reg <= wcnt_next;
            por_reg <= por_next;
            released_reg <= released_next;
            mode_reg <= mode_next;
            bodoff_reg <= bodoff_next;
            osc_en_reg <= osc_en_next;
        end
    end

    // hold at once with internal reset
    assign cpu_hold = state_reg != ST_RUN || !sys_reset_n;
    assign fast_osc_enable = osc_en_reg;

    // ************************************************************
    // APB slave and configuration registers
    // ************************************************************
    assign idx = paddr[9:2];
    assign mapped = paddr[1:0] == 2'h0 &&
                    (idx == IDX_SRC || idx == IDX_DIV || idx == IDX_TRIM || idx == IDX_STATUS || idx == IDX_CCP);
    assign wr = psel && penable && pwrite && mapped;

    always_comb begin
        src_next = src_reg;
        div_next = div_reg;
        trim_next = trim_reg;
        win_next = win_reg;
        rdata_next = rdata_reg;
        if (win_reg != 3'h0 && sys_tick) begin
            win_next = win_reg - 3'h1;
        end
        if (wr && idx == IDX_CCP) begin
            win_next = (pwdata[7:0] == UNLOCK_SIGNATURE) ? UNLOCK_WINDOW_TICKS : 3'h0;
        end
        if (wr && (idx == IDX_SRC || idx == IDX_DIV)) begin
            win_next = 3'h0;
        end
        if (wr && idx == IDX_SRC && win_reg != 3'h0 && pwdata[1:0] != SRC_RSVD) begin
            src_next = pwdata[1:0];
        end
        if (wr && idx == IDX_DIV && win_reg != 3'h0 && pwdata[3:0] <= DIV_MAX) begin
            div_next = pwdata[3:0];
        end
        if (wr && idx == IDX_TRIM) begin
            trim_next = pwdata[7:0];
        end
        if (!released_reg) begin
            src_next = SRC_FAST;
            div_next = DIV_DEFAULT;
            win_next = 3'h0;
        end
        if (state_reg == ST_CONFIG) begin
            trim_next = factory_cal;
        end
        // Read data is captured in the setup phase
        if (psel && !penable) begin
            rdata_next = 32'h0000_0000;
            case (idx)
                IDX_SRC: rdata_next[1:0] = src_reg;
                IDX_DIV: rdata_next[3:0] = div_reg;
                IDX_TRIM: rdata_next[7:0] = trim_reg;
                IDX_CCP: rdata_next[0] = win_reg != 3'h0;
                IDX_STATUS: begin
                    rdata_next[STAT_BUSY_BIT] = !released_reg;
                    rdata_next[STAT_SLEEP_BIT] = state_reg == ST_SLEEP;
                    rdata_next[STAT_SRC_LSB +: 2] = active_src;
                    rdata_next[STAT_DIV_LSB +: 4] = active_div;
                end
                default: rdata_next = 32'h0000_0000;
            endcase
            if (paddr[1:0] != 2'h0) begin
                rdata_next = 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_reg <= SRC_FAST;
            div_reg <= DIV_DEFAULT;
            trim_reg <= 8'h00;
            win_reg <= 3'h0;
            rdata_reg <= 32'h0000_0000;
        end else begin
            src_reg <= src_next;
            div_reg <= div_next;
            trim_reg <= trim_next;
            win_reg <= win_next;
            rdata_reg <= rdata_next;
        end
    end

    assign prdata = rdata_reg;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign osc_trim = trim_reg;
endmodule

// File: pkg/clock_ctrl_pkg.sv
/*
 * Shared constants, types and helpers for the start-up sequencer and
 * main-clock configuration block.
 * Assumes a single 125 MHz register clock; all oscillator inputs are
 * sampled as ordinary signals in that domain.
 */
package clock_ctrl_pkg;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int unsigned PCLK_PERIOD_NS = 8;
    localparam int unsigned SLOW_OSC_HZ = 128000;
    localparam int unsigned RESET_DELAY_MS = 64;
    localparam int unsigned BOD_RESET_DELAY_MS = 128;
    localparam int unsigned RESET_DELAY_TICKS = RESET_DELAY_MS * SLOW_OSC_HZ / 1000;
    localparam int unsigned BOD_RESET_DELAY_TICKS = BOD_RESET_DELAY_MS * SLOW_OSC_HZ / 1000;
    localparam int unsigned BOD_WAKE_NS = 60000;
    localparam int unsigned BOD_WAKE_CYCLES = (BOD_WAKE_NS + PCLK_PERIOD_NS - 1) / PCLK_PERIOD_NS;
    localparam logic [15:0] OSC_START_TICKS = 16'h0006;
    localparam logic [15:0] CONFIG_LOAD_TICKS = 16'h0015;
    localparam logic [2:0] UNLOCK_WINDOW_TICKS = 3'h4;

    // ************************************************************
    // Register map (word index; byte address is four times it)
    // ************************************************************
    localparam logic [7:0] IDX_DIV = 8'h36;
    localparam logic [7:0] IDX_SRC = 8'h37;
    localparam logic [7:0] IDX_TRIM = 8'h39;
    localparam logic [7:0] IDX_STATUS = 8'h3a;
    localparam logic [7:0] IDX_CCP = 8'h3c;

    localparam logic [1:0] SRC_FAST = 2'h0;
    localparam logic [1:0] SRC_SLOW = 2'h1;
    localparam logic [1:0] SRC_EXT = 2'h2;
    localparam logic [1:0] SRC_RSVD = 2'h3;
    localparam logic [3:0] DIV_DEFAULT = 4'h3;
    localparam logic [3:0] DIV_MAX = 4'h8;

    localparam int unsigned STAT_BUSY_BIT = 0;
    localparam int unsigned STAT_SLEEP_BIT = 1;
    localparam int unsigned STAT_SRC_LSB = 2;
    localparam int unsigned STAT_DIV_LSB = 4;

    // ************************************************************
    // Sleep modes
    // ************************************************************
    localparam logic [2:0] MODE_IDLE = 3'h0;
    localparam logic [2:0] MODE_ADC = 3'h1;
    localparam logic [2:0] MODE_PDOWN = 3'h2;
    localparam logic [2:0] MODE_STBY = 3'h4;

    typedef enum logic [2:0] {
        ST_HOLD, ST_SUPPLY, ST_OSC, ST_CONFIG, ST_RUN, ST_SLEEP, ST_WAKE
    } seq_state_t;

    // Level follows the synchroniser once its last two stages agree
    function automatic logic [2:0] agree_filter(input logic [2:0] s2, input logic [2:0] s3,
                                                input logic [2:0] lvl);
        return (~(s2 ^ s3) & s3) | ((s2 ^ s3) & lvl);
    endfunction

    function automatic logic count_done(input logic [15:0] cnt, input logic [15:0] target);
        return (17'(cnt) + 17'h0_0001) >= 17'(target);
    endfunction

    function automatic logic [7:0] div_limit(input logic [3:0] code);
        return 8'((9'h001 << code) - 9'h001);
    endfunction

endpackage

// File: core/clock_source_mux.sv
/*
 * Glitch-free main clock source selector.
 * Assumes the three oscillator inputs are slow against pclk (below a
 * quarter of its rate); each passes three flip-flops before use.
 */
`timescale 1ns/1ps
module clock_source_mux (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [2:0] osc_in,
    input wire logic [1:0] sel,
    output logic main_clk,
    output logic main_tick,
    output logic [2:0] src_tick,
    output logic [1:0] active_sel
);
    import clock_ctrl_pkg::*;

    logic [2:0] s1_reg, s2_reg, s3_reg, lvl_reg, prev_reg;
    logic [2:0] lvl_next;
    logic [1:0] cur_reg, cur_next;
    logic main_clk_reg, main_clk_next;

    // ************************************************************
    // Source sampling
    // ************************************************************
    always_comb begin
        lvl_next = agree_filter(s2_reg, s3_reg, lvl_reg);
        cur_next = cur_reg;
        if (sel != cur_reg && sel != SRC_RSVD && !lvl_reg[cur_reg] && !lvl_reg[sel]) begin
            cur_next = sel;
        end
        main_clk_next = lvl_reg[cur_next];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_reg <= 3'h0;
            s2_reg <= 3'h0;
            s3_reg <= 3'h0;
            lvl_reg <= 3'h0;
            prev_reg <= 3'h0;
            cur_reg <= SRC_FAST;
            main_clk_reg <= 1'b0;
        end else begin
            s1_reg <= osc_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            lvl_reg <= lvl_next;
            prev_reg <= lvl_reg;
            cur_reg <= cur_next;
            main_clk_reg <= main_clk_next;
        end
    end

    // Both sources sit low at a change-over, so no extra edge appears
    assign src_tick = lvl_reg & ~prev_reg;
    assign main_tick = src_tick[cur_reg];
    assign main_clk = main_clk_reg;
    assign active_sel = cur_reg;
endmodule

// File: core/system_clock_prescaler.sv
/*
 * Power-of-two system clock divider driven by main clock ticks.
 * Assumes the requested code is already limited to the legal range.
 */
`timescale 1ns/1ps
module system_clock_prescaler (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic main_tick,
    input wire logic main_clk,
    input wire logic [3:0] code,
    output logic sys_tick,
    output logic sys_clk,
    output logic [3:0] active_code
);
    import clock_ctrl_pkg::*;

    logic [7:0] cnt_reg, cnt_next;
    logic [3:0] act_reg, act_next;
    logic clk_reg, clk_next;
    logic wrap;

    // ************************************************************
    // Divider
    // ************************************************************
    always_comb begin
        wrap = main_tick && cnt_reg == div_limit(act_reg);
        cnt_next = cnt_reg;
        act_next = act_reg;
        if (wrap) begin
            cnt_next = 8'h00;
            act_next = code;
        end else if (main_tick) begin
            cnt_next = cnt_reg + 8'h01;
        end
        if (act_next == 4'h0) begin
            clk_next = main_clk;
        end else begin
            clk_next = cnt_next <= (div_limit(act_next) >> 1);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= 8'h00;
            act_reg <= DIV_DEFAULT;
            clk_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            act_reg <= act_next;
            clk_reg <= clk_next;
        end
    end

    assign sys_tick = wrap;
    assign sys_clk = clk_reg;
    assign active_code = act_reg;
endmodule

// File: dv/clock_ctrl_assertions.sv
/* Port checker for the start-up sequencer and clock select block.
   Assumes it is bound into startup_and_clock_select, oscillators below pclk/4. */
`timescale 1ns/1ps
module clock_ctrl_assertions
    import clock_ctrl_pkg::*;
#(
    parameter int unsigned RESET_TICKS = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [9:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic ext_reset_n,
    input wire logic bod_reset,
    input wire logic wdt_reset,
    input wire logic sys_reset_n,
    input wire logic cpu_hold,
    input wire logic fast_osc_enable,
    input wire logic sys_tick,
    input wire logic [7:0] osc_trim
);
    logic [15:0] low_cnt_reg;
    logic [15:0] low_cnt_next;
    logic trim_wr;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Cycles spent in internal reset; each slow tick takes at least 4 pclk
    always_comb begin
        low_cnt_next = sys_reset_n ? 16'h0000 : low_cnt_reg + 16'h0001;
        trim_wr = sys_reset_n && psel && penable && pwrite && paddr == {IDX_TRIM, 2'b00};
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_cnt_reg <= 16'h0000;
        end else begin
            low_cnt_reg <= low_cnt_next;
        end
    end
    reset_now_a: assert property ((!ext_reset_n || bod_reset || wdt_reset) |-> !sys_reset_n)
        else $error("internal reset not asserted at once");
    hold_in_reset_a: assert property (!sys_reset_n |-> cpu_hold)
        else $error("cpu released during reset");
    startup_long_a: assert property ($rose(sys_reset_n) |-> low_cnt_reg >= 16'(4 * (RESET_TICKS + 27)))
        else $error("start-up sequence too short");
    ready_high_a: assert property (psel && penable |-> pready)
        else $error("pready low in access");
    align_error_a: assert property (psel && penable && paddr[1:0] != 2'b00 |-> pslverr)
        else $error("misaligned access not refused");
    trim_write_a: assert property (trim_wr |=> osc_trim == $past(pwdata[7:0]))
        else $error("trim write lost");
    trim_hold_a: assert property (sys_reset_n && !trim_wr |=> $stable(osc_trim))
        else $error("trim changed without write");
    tick_single_a: assert property (sys_tick |=> !sys_tick)
        else $error("system tick wider than one cycle");
    osc_run_a: assert property (!cpu_hold |-> fast_osc_enable)
        else $error("oscillator off while running");
endmodule
bind startup_and_clock_select clock_ctrl_assertions #(.RESET_TICKS(RESET_TICKS)) i_chk (.*);

// File: dv/testbench.sv
/* Self-checking bench for startup_and_clock_select over APB.
   Assumes the package, design and bound checker are compiled first. */
`timescale 1ns/1ps
module testbench;
    import clock_ctrl_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic [9:0] paddr;
    logic [31:0] pwdata, prdata, rd, prev;
    logic clk_fast_osc, clk_slow_osc, clk_ext, ext_reset_n, bod_reset, wdt_reset, bod_enable;
    logic [7:0] factory_cal, osc_trim;
    logic sleep_req, bod_sleep_off, wake_event, sys_reset_n, cpu_hold, fast_osc_enable, main_clk, sys_clk, sys_tick;
    logic [2:0] sleep_mode;
    int mismatches, compares, osc_cnt, k;
    startup_and_clock_select #(.RESET_TICKS(8), .BOD_RESET_TICKS(16), .BOD_WAKE_TICKS(20)) i_dut (.*);
    always #4 pclk = ~pclk;
    always @(posedge pclk) begin
        osc_cnt <= osc_cnt + 1;
        clk_fast_osc <= (osc_cnt % 6) < 3;
        clk_slow_osc <= (osc_cnt % 20) < 10;
        clk_ext <= (osc_cnt % 10) < 5;
    end
    task summarize;
        $display("compares=%0d mismatches=%0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task limit(input int n, input int m);
        if (n >= m) begin
            mismatches++;
            summarize();
        end
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
            mismatches++;
        end
    endtask
    task apb(input logic w, input logic [9:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        limit(n, 50);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input logic [7:0] i, input logic [31:0] d);
        apb(1'b1, {i, 2'b00}, d);
    endtask
    task rdc(input logic [7:0] i, input logic [31:0] exp);
        apb(1'b0, {i, 2'b00}, 32'h0000_0000);
        chk(rd, exp);
    endtask
    task unlock;
        wr(IDX_CCP, 32'h0000_005a);
    endtask
    task wait_run;
        int n;
        n = 0;
        while ((sys_reset_n !== 1'b1 || cpu_hold !== 1'b0) && n < 20000) begin
            @(posedge pclk);
            n++;
        end
        limit(n, 20000);
    endtask
    // Lets c system clock periods pass, bounded
    task ticks(input int c);
        int n;
        n = 0;
        while (c > 0 && n < 5000) begin
            @(posedge pclk);
            n++;
            c -= sys_tick;
        end
        limit(n, 5000);
    endtask
    // Rising edges of main and system clock over 960 cycles
    task edges(input int main_lo, input int sys_lo);
        int nm, ns;
        logic pm, ps;
        nm = 0;
        ns = 0;
        pm = main_clk;
        ps = sys_clk;
        repeat (960) begin
            @(posedge pclk);
            nm += (main_clk && !pm);
            ns += (sys_clk && !ps);
            pm = main_clk;
            ps = sys_clk;
        end
        chk(nm >= main_lo && nm <= main_lo + 2, 1'b1);
        chk(ns >= sys_lo && ns <= sys_lo + 2, 1'b1);
    endtask
    // Wake latency in pclk, counted from the wake request
    task nap(input logic [2:0] m, input logic off, input int lo, input int hi);
        int n;
        repeat (8) @(posedge pclk);
        sleep_req <= 1'b1;
        sleep_mode <= m;
        bod_sleep_off <= off;
        @(posedge pclk);
        sleep_req <= 1'b0;
        @(posedge pclk);
        @(posedge pclk);
        chk(cpu_hold, 1'b1);
        chk(fast_osc_enable, m != MODE_PDOWN);
        wake_event <= 1'b1;
        n = 0;
        while (cpu_hold !== 1'b0 && n < 10000) begin
            @(posedge pclk);
            n++;
        end
        limit(n, 10000);
        wake_event <= 1'b0;
        chk(n >= lo && n <= hi, 1'b1);
    endtask
    initial begin
        {pclk, presetn, psel, penable, pwrite, wdt_reset, sleep_req, bod_sleep_off, wake_event, bod_reset} = '0;
        {paddr, pwdata, sleep_mode} = '0;
        ext_reset_n = 1'b1;
        bod_enable = 1'b1;
        factory_cal = 8'h9c;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        wait_run();
        rdc(IDX_DIV, 32'h0000_0003);
        rdc(IDX_SRC, 32'h0000_0000);
        rdc(IDX_TRIM, 32'h0000_009c);
        rdc(IDX_STATUS, 32'h0000_0030);
        edges(159, 19);
        $display("test reset_values done");
        wr(IDX_DIV, 32'h0000_0000);
        rdc(IDX_DIV, 32'h0000_0003);
        wr(IDX_SRC, 32'h0000_0001);
        rdc(IDX_SRC, 32'h0000_0000);
        prev = 32'h0000_0003;
        for (k = 0; k < 16; k++) begin
            unlock();
            wr(IDX_DIV, k);
            prev = (k <= 8) ? k : prev;
            rdc(IDX_DIV, prev);
        end
        unlock();
        wr(IDX_DIV, 32'h0000_0003);
        for (k = 0; k < 4; k++) begin
            unlock();
            wr(IDX_SRC, k);
            prev = (k < 3) ? k : prev;
            rdc(IDX_SRC, prev);
        end
        unlock();
        wr(IDX_SRC, 32'h0000_0000);
        unlock();
        ticks(5);
        wr(IDX_DIV, 32'h0000_0005);
        rdc(IDX_DIV, 32'h0000_0003);
        $display("test protected_fields done");
        wr(IDX_TRIM, 32'h0000_00ff);
        rdc(IDX_TRIM, 32'h0000_00ff);
        wr(IDX_TRIM, 32'h0000_0000);
        rdc(IDX_TRIM, 32'h0000_0000);
        apb(1'b0, 10'h100, 32'h0000_0000);
        chk({rd[30:0], er}, 32'h0000_0001);
        apb(1'b1, 10'h0da, 32'h0000_0001);
        chk(er, 1'b1);
        $display("test trim_and_map done");
        nap(MODE_IDLE, 1'b0, 2, 8);
        nap(MODE_ADC, 1'b0, 2, 8);
        nap(MODE_STBY, 1'b0, 2, 8);
        nap(MODE_STBY, 1'b1, 20, 30);
        nap(MODE_PDOWN, 1'b0, 30, 50);
        nap(MODE_PDOWN, 1'b1, 30, 70);
        $display("test wake_latency done");
        unlock();
        wr(IDX_DIV, 32'h0000_0000);
        wdt_reset <= 1'b1;
        @(posedge pclk);
        chk(sys_reset_n, 1'b0);
        wdt_reset <= 1'b0;
        wait_run();
        rdc(IDX_DIV, 32'h0000_0003);
        $display("test watchdog_restart done");
        summarize();
    end
endmodule
